// >>> shared/ppe_regs.vh
// Register map constants for the per-port police, queue index and VID
// replacement registers. Byte addresses are offsets within a port block.
`ifndef PPE_REGS_VH
`define PPE_REGS_VH

`define PPE_ADDR_W 12
`define PPE_OFS_POLICE 12'h80C
`define PPE_OFS_QIDX 12'h900
`define PPE_OFS_VIDREP 12'h904

`define PPE_POL_EN 0
`define PPE_POL_BLIND 1
`define PPE_POL_DROP_SRP 2
`define PPE_POL_REMAP 3
`define PPE_POL_MARK 4
`define PPE_POL_NIPC_LO 5
`define PPE_POL_NIPC_HI 6
`define PPE_POL_PORTQ 7
`define PPE_POL_PTYPE_LO 8
`define PPE_POL_PTYPE_HI 9
`define PPE_POL_DROP_ALL 10
`define PPE_POL_DROPPED 11
`define PPE_POL_MASK 32'h0000_0FFF
`define PPE_POL_RESET 32'h0000_0020

`define PPE_QIDX_MASK 32'h0000_0003
`define PPE_QIDX_RESET 32'h0000_0000
`define PPE_VIDREP_MASK 32'h0000_0001
`define PPE_VIDREP_RESET 32'h0000_0000

`define PPE_PIDX_LO 16
`define PPE_PIDX_HI 18
`define PPE_QPTR_LO 0
`define PPE_QPTR_HI 1

`endif

// >>> test/ppe_regs_sva.sv
// Assertions on the port police, queue index and VID replacement block.
// Assumes binding to ppe_port_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ppe_regs_sva
(
  // Clock, reset, bus write strobe and pointer register contents
  input wire clk_i,
  input wire rst_n_i,
  input wire reg_wr_i,
  input wire [31:0] port_pointer_i,
  // Decoded controls and the double tagging input
  input wire police_enable_o,
  input wire wred_enable_o,
  input wire color_blind_o,
  input wire color_aware_o,
  input wire srp_drop_allow_o,
  input wire color_remap_en_o,
  input wire per_port_policing_o,
  input wire [2:0] police_port_sel_o,
  input wire [1:0] police_queue_sel_o,
  input wire [1:0] tx_queue_sel_o,
  input wire double_tag_en_i,
  input wire vid_replace_o,
  input wire vid_replace_outer_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_no_wr;
    !reg_wr_i;
  endsequence
  chk_en_pair: assert property (police_enable_o == wred_enable_o)
    else $error("enable outputs differ");
  chk_aware_mode: assert property (color_aware_o ==
    (police_enable_o && !color_blind_o)) else $error("aware mode wrong");
  chk_srp_gate: assert property (srp_drop_allow_o |-> wred_enable_o)
    else $error("srp drop without wred");
  chk_remap_gate: assert property (color_remap_en_o |-> color_aware_o)
    else $error("remap outside aware mode");
  chk_shared_port: assert property (!per_port_policing_o |->
    police_port_sel_o == 3'h0) else $error("shared mode port not zero");
  chk_queue_ptr: assert property (police_queue_sel_o ==
    port_pointer_i[1:0]) else $error("queue pointer mismatch");
  chk_outer_tag: assert property (vid_replace_outer_o ==
    (vid_replace_o && double_tag_en_i)) else $error("outer replace wrong");
  chk_qidx_hold: assert property (s_no_wr |=> $stable(tx_queue_sel_o))
    else $error("queue index moved without write");
endmodule
bind ppe_port_regs ppe_regs_sva u_ppe_regs_sva (.*);
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the port police and egress register block.
// Drives the strobe bus directly; there is no partner model.
`timescale 1ns/1ps
`include "ppe_regs.vh"
`default_nettype none
module tb_top;
  logic clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic double_tag_en_i = 1'h0, reg_ack_o, reg_err_o, police_enable_o;
  logic [11:0] reg_addr_i = 12'h0;
  logic [3:0] reg_be_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, port_pointer_i = 32'h0005_0002, reg_rdata_o;
  logic wred_enable_o, color_blind_o, color_aware_o, srp_drop_allow_o;
  logic color_remap_en_o, dscp_color_mark_en_o, per_port_policing_o;
  logic wred_drop_all_o, count_dropped_only_o, vid_replace_o;
  logic vid_replace_outer_o, vid_replace_inner_o;
  logic [1:0] non_ip_frame_color_o, policing_monitor_counter_sel_o;
  logic [1:0] police_queue_sel_o, tx_queue_sel_o;
  logic [2:0] police_port_sel_o;
  logic [31:0] pv [4] = '{32'hFFFF_FFFF, 32'h0000_0009, 32'h0000_0A55,
    32'h0000_05AA};
  integer err_total = 0, checks = 0;
  logic [31:0] rq;
  logic re;
  ppe_port_regs u_ppe_port_regs (.*);
  always #10 clk_i = ~clk_i;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ack is fixed at one cycle after the strobe, so no wait loop is needed.
  // Read data and error stand one cycle, so they are captured with the ack;
  // an idle cycle follows so the next call never re-raises a strobe at once.
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_be_i = b;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    q = reg_rdata_o;
    e = reg_err_o;
    cmp(reg_ack_o, 32'h1);
    @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset;
    acc(0, `PPE_OFS_POLICE, 4'hF, 32'h0, rq, re);
    cmp(rq, `PPE_POL_RESET);
    cmp(non_ip_frame_color_o, 32'h1);
  endtask
  task automatic t_police;
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = pv[i];
      acc(1, `PPE_OFS_POLICE, 4'hF, d, rq, re);
      cmp({police_enable_o, wred_enable_o, color_blind_o, color_aware_o,
        srp_drop_allow_o, color_remap_en_o, dscp_color_mark_en_o,
        non_ip_frame_color_o, per_port_policing_o,
        policing_monitor_counter_sel_o, wred_drop_all_o, count_dropped_only_o,
        police_port_sel_o}, {d[0], d[0], d[0] & d[1], d[0] & ~d[1],
        d[0] & d[2], d[0] & ~d[1] & d[3], d[4], d[6:5], d[7], d[9:8], d[10],
        d[11], d[7] ? 3'h5 : 3'h0});
      acc(0, `PPE_OFS_POLICE, 4'hF, 32'h0, rq, re);
      cmp(rq, d & `PPE_POL_MASK);
    end
  endtask
  task automatic t_qidx;
    acc(1, 12'h903, 4'h8, 32'h3, rq, re);
    acc(1, `PPE_OFS_QIDX, 4'h7, 32'hFFFF_FFFF, rq, re);
    cmp(tx_queue_sel_o, 32'h3);
    acc(0, `PPE_OFS_QIDX, 4'hF, 32'h0, rq, re);
    cmp(rq, 32'h3);
  endtask
  task automatic t_vid;
    acc(1, `PPE_OFS_VIDREP, 4'hF, 32'hFFFF_FFFF, rq, re);
    cmp({vid_replace_o, vid_replace_inner_o}, 32'h3);
    double_tag_en_i = 1'h1;
    #1;
    cmp({vid_replace_outer_o, vid_replace_inner_o}, 32'h2);
  endtask
  task automatic t_bad;
    acc(1, 12'h808, 4'hF, 32'hFFFF_FFFF, rq, re);
    cmp(re, 32'h1);
    acc(0, 12'h808, 4'hF, 32'h0, rq, re);
    cmp(re, 32'h1);
    cmp(rq, 32'h0);
  endtask
  task automatic conclude;
    $display("err_total %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    #1;
    rst_n_i = 1'h1;
    t_reset();
    t_police();
    t_qidx();
    t_vid();
    t_bad();
    conclude();
  end
endmodule
`default_nettype wire

// >>> verilog/ppe_port_regs.v
// Per-port policing control, transmit queue index and VID replacement
// registers, with the decoded control outputs for the policing datapath,
// the queue scheduler register file and the egress tagger.
// Assumes a synchronous register bus in the clk_i domain with byte enables
// on a 32-bit word, and that the pointer register lives elsewhere.
//
// Functional notes
// - Bit 0 enables policing and WRED together for the port.
// - Bit 1 picks color blind when one, color aware when zero.
// - Bit 2 lets WRED drop SRP frames; clear protects them.
// - Bit 3 remaps DSCP color in color aware mode; clear uses it unchanged.
// - Bit 4 enables marking the policing color into the DSCP field.
// - Bits 6:5 give non-IP frame color in color aware mode, reset 01b.
// - Bit 7 selects per-port per-queue policing; clear shares per queue.
// - Per-queue-only rates use port index zero and apply to all ports.
// - Bits 9:8 choose monitor count: red, yellow, green or dropped.
// - Bit 10 drops all above WRED max threshold; clear uses probability.
// - Bit 11 makes color counters count only dropped frames.
// - Queue index bits 1:0 select queue for indexed registers.
// - Queue index also reachable as a byte at the word's top address.
// - Replacement bit overwrites non-zero egress VIDs with port default.
// - With double tagging, the outer service tag ID is replaced.
// - Pointer port index and queue pointer select indirect locations.
`timescale 1ns/1ps
`include "ppe_regs.vh"
`default_nettype none

module ppe_port_regs
(
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register bus
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [`PPE_ADDR_W-1:0] reg_addr_i,
  input wire [3:0] reg_be_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output reg reg_ack_o,
  output reg reg_err_o,
  // Pointer register contents from the port pointer block
  input wire [31:0] port_pointer_i,
  // Policing and WRED controls
  output wire police_enable_o,
  output wire wred_enable_o,
  output wire color_blind_o,
  output wire color_aware_o,
  output wire srp_drop_allow_o,
  output wire color_remap_en_o,
  output wire dscp_color_mark_en_o,
  output wire [1:0] non_ip_frame_color_o,
  output wire per_port_policing_o,
  output wire [1:0] policing_monitor_counter_sel_o,
  output wire wred_drop_all_o,
  output wire count_dropped_only_o,
  // Indirect policing location selection
  output wire [2:0] police_port_sel_o,
  output wire [1:0] police_queue_sel_o,
  // Indexed queue register selection
  output wire [1:0] tx_queue_sel_o,
  // Egress tagger
  input wire double_tag_en_i,
  output wire vid_replace_o,
  output wire vid_replace_outer_o,
  output wire vid_replace_inner_o
);

  reg [31:0] port_police_control;
  reg [31:0] tx_queue_index;
  reg [31:0] tx_queue_vid_replace;
  reg [31:0] next_rdata;
  reg next_err;
  wire hit_pol;
  wire hit_qidx;
  wire hit_vid;
  wire [31:0] bmask;
  localparam [`PPE_ADDR_W-1:0] OFS_POL = `PPE_OFS_POLICE;
  localparam [`PPE_ADDR_W-1:0] OFS_QIDX = `PPE_OFS_QIDX;
  localparam [`PPE_ADDR_W-1:0] OFS_VID = `PPE_OFS_VIDREP;

  assign hit_pol = reg_addr_i[`PPE_ADDR_W-1:2] == OFS_POL[`PPE_ADDR_W-1:2];
  assign hit_qidx = reg_addr_i[`PPE_ADDR_W-1:2] == OFS_QIDX[`PPE_ADDR_W-1:2];
  assign hit_vid = reg_addr_i[`PPE_ADDR_W-1:2] == OFS_VID[`PPE_ADDR_W-1:2];

  // Lane 3 carries bits 7:0 so a byte access at offset 3 of the word
  // reaches the index field; lane order is big-endian within the word.
  assign bmask = {{8{reg_be_i[0]}}, {8{reg_be_i[1]}},
                  {8{reg_be_i[2]}}, {8{reg_be_i[3]}}};

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_police_control <= `PPE_POL_RESET;
      tx_queue_index <= `PPE_QIDX_RESET;
      tx_queue_vid_replace <= `PPE_VIDREP_RESET;
    end
    else if (reg_wr_i)
    begin
      // Reserved bits are masked so they can never become set.
      if (hit_pol)
        port_police_control <= ((port_police_control & ~bmask) |
          (reg_wdata_i & bmask)) & `PPE_POL_MASK;
      if (hit_qidx)
        tx_queue_index <= ((tx_queue_index & ~bmask) |
          (reg_wdata_i & bmask)) & `PPE_QIDX_MASK;
      if (hit_vid)
        tx_queue_vid_replace <= ((tx_queue_vid_replace & ~bmask) |
          (reg_wdata_i & bmask)) & `PPE_VIDREP_MASK;
    end
  end

  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (hit_pol)
      next_rdata = port_police_control;
    else if (hit_qidx)
      next_rdata = tx_queue_index;
    else if (hit_vid)
      next_rdata = tx_queue_vid_replace;
    else
      next_err = 1'b1;
  end

  // Unmapped addresses read zero and raise an error flag with the ack.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 32'h0000_0000;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end
    else
    begin
      reg_ack_o <= reg_wr_i | reg_rd_i;
      reg_err_o <= (reg_wr_i | reg_rd_i) & next_err;
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
    end
  end

  assign police_enable_o = port_police_control[`PPE_POL_EN];
  assign wred_enable_o = port_police_control[`PPE_POL_EN];
  assign color_blind_o = police_enable_o &
    port_police_control[`PPE_POL_BLIND];
  assign color_aware_o = police_enable_o &
    ~port_police_control[`PPE_POL_BLIND];
  assign srp_drop_allow_o = wred_enable_o &
    port_police_control[`PPE_POL_DROP_SRP];
  assign color_remap_en_o = color_aware_o &
    port_police_control[`PPE_POL_REMAP];
  assign dscp_color_mark_en_o = port_police_control[`PPE_POL_MARK];
  assign non_ip_frame_color_o =
    port_police_control[`PPE_POL_NIPC_HI:`PPE_POL_NIPC_LO];
  assign per_port_policing_o = port_police_control[`PPE_POL_PORTQ];
  assign policing_monitor_counter_sel_o =
    port_police_control[`PPE_POL_PTYPE_HI:`PPE_POL_PTYPE_LO];
  assign wred_drop_all_o = port_police_control[`PPE_POL_DROP_ALL];
  assign count_dropped_only_o =
    port_police_control[`PPE_POL_DROPPED];

  // In shared mode every port uses the rate set stored under port zero.
  assign police_port_sel_o = per_port_policing_o ?
    port_pointer_i[`PPE_PIDX_HI:`PPE_PIDX_LO] : 3'h0;
  assign police_queue_sel_o =
    port_pointer_i[`PPE_QPTR_HI:`PPE_QPTR_LO];

  assign tx_queue_sel_o = tx_queue_index[1:0];

  assign vid_replace_o = tx_queue_vid_replace[0];
  assign vid_replace_outer_o = vid_replace_o & double_tag_en_i;
  assign vid_replace_inner_o = vid_replace_o & ~double_tag_en_i;

endmodule

`default_nettype wire
